// file: hdl/htc_defines.vh
// constants for the humidity/temperature result path
`ifndef HTC_DEFINES_VH
`define HTC_DEFINES_VH

// resolution codes (two config bits)
`define HTC_RES_DEFAULT   2'h0
`define HTC_RES_8_12      2'h1
`define HTC_RES_10_13     2'h2
`define HTC_RES_11_11     2'h3

// resolution in bits per code, humidity and temperature
`define HTC_RH_BITS_0     5'h0c
`define HTC_RH_BITS_1     5'h08
`define HTC_RH_BITS_2     5'h0a
`define HTC_RH_BITS_3     5'h0b
`define HTC_T_BITS_0      5'h0e
`define HTC_T_BITS_1      5'h0c
`define HTC_T_BITS_2      5'h0d
`define HTC_T_BITS_3      5'h0b

// longest measurement durations in ms
`define HTC_RH_MS_12      7'h1d
`define HTC_RH_MS_8       7'h04
`define HTC_RH_MS_10      7'h09
`define HTC_RH_MS_11      7'h0f
`define HTC_T_MS_14       7'h55
`define HTC_T_MS_12       7'h16
`define HTC_T_MS_13       7'h2b
`define HTC_T_MS_11       7'h0b

// millisecond tick
`define HTC_MS_NS         1000000
`define HTC_CLK_PERIOD_NS 40
`define HTC_MS_CYCLES     (`HTC_MS_NS / `HTC_CLK_PERIOD_NS)

// result word layout, fifo size and ack slot bit index
`define HTC_WORD_W        16
`define HTC_STATUS_TYPE   1
`define HTC_FIFO_DEPTH    8
`define HTC_FIFO_AW       3
`define HTC_BIT_ACK       4'h8

`endif

// file: hdl/htc_fifo.v
// synchronous result fifo with valid/ready on both sides
`timescale 1ns/1ns
module htc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0]      level_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push = in_valid_in & in_ready_out;
  wire pop  = out_valid_out & out_ready_in;

  assign in_ready_out  = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr];
  assign level_out     = count;

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // htc_fifo

// file: hdl/htc_sensor_result.v
// sensor-side measurement timing, result words and two-wire byte output
`timescale 1ns/1ns
`include "htc_defines.vh"

// Contract
// - after reset, humidity uses 12 bits and temperature 14 bits until reconfigured.
// - result goes out as two bytes, high byte first, each MSB first.
// - every result byte is followed by one acknowledge bit slot.
// - measurement durations are the same under either protocol; waits not shortened.
module htc_sensor_result #(
  parameter MS_CYCLES = `HTC_MS_CYCLES
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        meas_req_in,
  input  wire        meas_temp_in,
  input  wire        res_wr_in,
  input  wire [1:0]  res_code_in,
  input  wire [15:0] adc_sample_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out_out,
  output reg         sda_oe_out,
  output wire        meas_busy_out,
  output reg  [1:0]  res_code_out,
  output wire [3:0]  fifo_level_out
);

  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------
  function [4:0] res_bits;
    input [1:0] code;
    input       is_temp;
    begin
      case ({is_temp, code})
        3'h0:    res_bits = `HTC_RH_BITS_0;
        3'h1:    res_bits = `HTC_RH_BITS_1;
        3'h2:    res_bits = `HTC_RH_BITS_2;
        3'h3:    res_bits = `HTC_RH_BITS_3;
        3'h4:    res_bits = `HTC_T_BITS_0;
        3'h5:    res_bits = `HTC_T_BITS_1;
        3'h6:    res_bits = `HTC_T_BITS_2;
        default: res_bits = `HTC_T_BITS_3;
      endcase
    end
  endfunction

  function [6:0] meas_ms;
    input [1:0] code;
    input       is_temp;
    begin
      case ({is_temp, code})
        3'h0:    meas_ms = `HTC_RH_MS_12;
        3'h1:    meas_ms = `HTC_RH_MS_8;
        3'h2:    meas_ms = `HTC_RH_MS_10;
        3'h3:    meas_ms = `HTC_RH_MS_11;
        3'h4:    meas_ms = `HTC_T_MS_14;
        3'h5:    meas_ms = `HTC_T_MS_12;
        3'h6:    meas_ms = `HTC_T_MS_13;
        default: meas_ms = `HTC_T_MS_11;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // resolution configuration
  // --------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_code_out <= `HTC_RES_DEFAULT;
    end else if (res_wr_in) begin
      res_code_out <= res_code_in;
    end
  end

  // --------------------------------------------------------------
  // measurement timing and result word
  // --------------------------------------------------------------
  localparam M_IDLE = 2'h0;
  localparam M_RUN  = 2'h1;
  localparam M_PUSH = 2'h2;

  reg  [1:0]  m_state;
  reg  [1:0]  next_m_state;
  reg         m_temp;
  reg  [6:0]  ms_left;
  reg  [24:0] tick_cnt;
  reg  [15:0] result;
  wire        fifo_in_ready;
  wire        tick = (tick_cnt == MS_CYCLES[24:0] - 25'h1);
  wire [4:0]  nbits = res_bits(res_code_out, m_temp);
  wire [15:0] keep_mask = 16'hffff << (5'h10 - nbits);

  assign meas_busy_out = (m_state != M_IDLE);

  always @* begin
    next_m_state = m_state;
    case (m_state)
      M_IDLE: begin
        if (meas_req_in) begin
          next_m_state = M_RUN;
        end
      end
      M_RUN: begin
        if (tick && ms_left == 7'h01) begin
          next_m_state = M_PUSH;
        end
      end
      M_PUSH: begin
        if (fifo_in_ready) begin
          next_m_state = M_IDLE;
        end
      end
      default: next_m_state = M_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m_state  <= M_IDLE;
      m_temp   <= 1'b0;
      ms_left  <= 7'h00;
      tick_cnt <= 25'h0;
      result   <= 16'h0000;
    end else begin
      m_state <= next_m_state;
      if (m_state == M_IDLE && meas_req_in) begin
        m_temp   <= meas_temp_in;
        ms_left  <= meas_ms(res_code_out, meas_temp_in);
        tick_cnt <= 25'h0;
      end else if (m_state == M_RUN) begin
        tick_cnt <= tick ? 25'h0 : tick_cnt + 25'h1;
        if (tick) begin
          ms_left <= ms_left - 7'h01;
        end
        if (tick && ms_left == 7'h01) begin
          // left-aligned sample, unused low bits zero, type in status bit
          result <= (adc_sample_in & keep_mask) | {14'h0000, ~m_temp, 1'b0};
        end
      end
    end
  end

  // --------------------------------------------------------------
  // result fifo
  // --------------------------------------------------------------
  wire        head_valid;
  wire [15:0] head_word;
  reg         fifo_pop;

  htc_fifo #(
    .WIDTH (`HTC_WORD_W),
    .DEPTH (`HTC_FIFO_DEPTH),
    .AW    (`HTC_FIFO_AW)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (m_state == M_PUSH),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (result),
    .out_valid_out (head_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (head_word),
    .level_out     (fifo_level_out)
  );

  // --------------------------------------------------------------
  // pin synchronisers and bus conditions
  // --------------------------------------------------------------
  reg scl_s1;
  reg scl_s2;
  reg scl_d;
  reg sda_s1;
  reg sda_s2;
  reg sda_d;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  wire scl_rise  = scl_s2 & ~scl_d;
  wire scl_fall  = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // --------------------------------------------------------------
  // byte output with acknowledge slots
  // --------------------------------------------------------------
  localparam L_IDLE = 1'b0;
  localparam L_SEND = 1'b1;

  reg       l_state;
  reg [3:0] bit_idx;
  reg       byte_sel;
  wire [7:0] cur_byte = byte_sel ? head_word[7:0] : head_word[15:8];
  wire       cur_bit  = cur_byte[3'h7 - bit_idx[2:0]];

  assign sda_out_out = 1'b0;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      l_state    <= L_IDLE;
      bit_idx    <= 4'h0;
      byte_sel   <= 1'b0;
      sda_oe_out <= 1'b0;
      fifo_pop   <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      if (bus_stop) begin
        l_state    <= L_IDLE;
        sda_oe_out <= 1'b0;
      end else if (bus_start) begin
        l_state    <= head_valid ? L_SEND : L_IDLE;
        bit_idx    <= 4'h0;
        byte_sel   <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (l_state == L_SEND) begin
        if (scl_fall) begin
          // pull low for a zero, release for a one or the ack slot
          sda_oe_out <= (bit_idx == `HTC_BIT_ACK) ? 1'b0 : ~cur_bit;
        end else if (scl_rise) begin
          if (bit_idx != `HTC_BIT_ACK) begin
            bit_idx <= bit_idx + 4'h1;
          end else if (!byte_sel && !sda_s2) begin
            byte_sel <= 1'b1;
            bit_idx  <= 4'h0;
          end else begin
            fifo_pop <= byte_sel;
            l_state  <= L_IDLE;
          end
        end
      end else begin
        sda_oe_out <= 1'b0;
      end
    end
  end

endmodule // htc_sensor_result

// file: verif/htc_sensor_result_asserts.sv
// port assertions for the sensor result block
`timescale 1ns/1ns
module htc_sensor_result_asserts #(
  parameter MS_CYCLES = 25000
) (
  input wire       clk_in,
  input wire       rst_n_in,
  input wire       meas_req_in,
  input wire       meas_temp_in,
  input wire       res_wr_in,
  input wire [1:0] res_code_in,
  input wire       scl_in,
  input wire       sda_oe_out,
  input wire       meas_busy_out,
  input wire [1:0] res_code_out,
  input wire [3:0] fifo_level_out
);
  int ms_tab [8] = '{8'h1d, 8'h04, 8'h09, 8'h0f, 8'h55, 8'h16, 8'h2b, 8'h0b};
  int cnt;
  int need;
  // ----------------------------------------
  // measurement length tracking
  // ----------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt  <= 0;
      need <= 0;
    end else if (meas_req_in && !meas_busy_out) begin
      cnt  <= 0;
      need <= ms_tab[{meas_temp_in, res_code_out}] * MS_CYCLES;
    end else if (meas_busy_out) begin
      cnt <= cnt + 1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_RES_RESET: assert property (!$past(rst_n_in) |-> res_code_out == 2'h0)
    else $error("resolution code not default after reset");
  AST_RES_LOAD: assert property (res_wr_in |=> res_code_out == $past(res_code_in))
    else $error("resolution code not loaded");
  AST_BUSY_RISE: assert property (meas_req_in && !meas_busy_out |=> meas_busy_out)
    else $error("busy not raised after request");
  AST_MEAS_MIN: assert property ($fell(meas_busy_out) |-> cnt >= need)
    else $error("measurement shorter than its duration");
  AST_STALL: assert property (meas_busy_out && cnt > need + 3 |-> fifo_level_out >= 4'h7)
    else $error("busy held with fifo room");
  AST_OE_HOLD: assert property (scl_in [*5] |-> $stable(sda_oe_out))
    else $error("data line changed while clock high");
endmodule // htc_sensor_result_asserts
bind htc_sensor_result htc_sensor_result_asserts #(.MS_CYCLES(MS_CYCLES)) i_asserts (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .meas_req_in(meas_req_in),
  .meas_temp_in(meas_temp_in), .res_wr_in(res_wr_in), .res_code_in(res_code_in),
  .scl_in(scl_in), .sda_oe_out(sda_oe_out), .meas_busy_out(meas_busy_out),
  .res_code_out(res_code_out), .fifo_level_out(fifo_level_out));

// file: verif/htc_bus_master.sv
// two-wire bus master model reading result words
`timescale 1ns/1ns
module htc_bus_master #(
  parameter HALF = 8
) (
  input  wire clk_in,
  input  wire sda_oe_in,
  output reg  scl_out,
  output wire sda_out
);
  reg msda;
  reg oe_seen;
  // pull-up: line high unless someone pulls low
  assign sda_out = msda & ~sda_oe_in;
  initial begin
    scl_out = 1'b1;
    msda    = 1'b1;
    oe_seen = 1'b0;
  end
  task automatic step(input logic c, input logic d);
    @(negedge clk_in);
    scl_out = c;
    msda    = d;
    repeat (HALF - 1) @(negedge clk_in);
  endtask
  task automatic read_word(input logic nack1, output logic [15:0] w);
    logic d;
    w       = 16'h0000;
    oe_seen = 1'b0;
    step(1'b1, 1'b0);
    for (int i = 0; i < 18; i++) begin
      d = (i == 8) ? nack1 : 1'b1;
      step(1'b0, msda);
      step(1'b0, d);
      step(1'b1, d);
      if (i == 8 || i == 17) begin
        oe_seen = oe_seen | sda_oe_in;
        if (i == 8 && nack1) break;
      end else begin
        w = {w[14:0], sda_out};
      end
    end
    step(1'b0, msda);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
endmodule // htc_bus_master

// file: verif/test_htc_sensor_result.sv
// self-checking bench for the sensor result block
`timescale 1ns/1ns
module test_htc_sensor_result;
  localparam MS = 4;
  reg         clk_in, rst_n_in, meas_req_in, meas_temp_in, res_wr_in;
  reg  [1:0]  res_code_in;
  reg  [15:0] adc_sample_in;
  wire        scl, sda, sda_oe, busy, sda_low;
  logic [15:0] last_w;
  wire [1:0]  res_now;
  wire [3:0]  level;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int ms_tab [8] = '{8'h1d, 8'h04, 8'h09, 8'h0f, 8'h55, 8'h16, 8'h2b, 8'h0b};
  int bit_tab [8] = '{8'h0c, 8'h08, 8'h0a, 8'h0b, 8'h0e, 8'h0c, 8'h0d, 8'h0b};
  htc_sensor_result #(.MS_CYCLES(MS)) i_htc_sensor_result (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .meas_req_in(meas_req_in),
    .meas_temp_in(meas_temp_in), .res_wr_in(res_wr_in), .res_code_in(res_code_in),
    .adc_sample_in(adc_sample_in), .scl_in(scl), .sda_in(sda), .sda_out_out(sda_low),
    .sda_oe_out(sda_oe), .meas_busy_out(busy), .res_code_out(res_now),
    .fifo_level_out(level));
  htc_bus_master i_htc_bus_master (
    .clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done;
    end
  end
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic nk, input logic [15:0] exp);
    logic [15:0] w;
    i_htc_bus_master.read_word(nk, w);
    last_w = w;
    chk("result word", exp, w);
    chk("ack slot drive", 16'h0000, {15'h0000, i_htc_bus_master.oe_seen});
  endtask
  task automatic req(input logic t);
    @(negedge clk_in);
    meas_req_in  = 1'b1;
    meas_temp_in = t;
    @(negedge clk_in);
    meas_req_in = 1'b0;
  endtask
  task automatic set_res(input logic [1:0] c);
    @(negedge clk_in);
    res_code_in = c;
    res_wr_in   = 1'b1;
    @(negedge clk_in);
    res_wr_in = 1'b0;
    @(negedge clk_in);
    chk("resolution code", {14'h0000, c}, {14'h0000, res_now});
  endtask
  task automatic t_reset;
    chk("resolution code", 16'h0000, {14'h0000, res_now});
    chk("fifo level", 16'h0000, {12'h000, level});
    chk("data drive", 16'h0000, {15'h0000, sda_oe});
    chk("data level", 16'h0000, {15'h0000, sda_low});
  endtask
  // receiver side: mask status bits, scale, legacy and ice forms
  task automatic conv(input logic t, input int bits, input logic [15:0] exp,
                      input logic [15:0] got);
    logic [15:0] sx;
    logic [15:0] sg;
    real         rx;
    real         rg;
    real         rl;
    real         tc;
    real         ix;
    real         ig;
    sx = exp & 16'hfffc;
    sg = got & 16'hfffc;
    tc = -10.0;
    chk("masked word", sx, sg);
    if (t) begin
      rx = -46.85 + 175.72 * sx / 65536.0;
      rg = -46.85 + 175.72 * sg / 65536.0;
      rl = -46.85 + 175.72 * (sg >> (16 - bits)) / (2.0 ** bits);
      chk("temperature", 16'(int'(rx * 100.0)), 16'(int'(rg * 100.0)));
      chk("legacy temperature", 16'(int'(rx * 100.0)), 16'(int'(rl * 100.0)));
    end else begin
      rx = -6.0 + 125.0 * sx / 65536.0;
      rg = -6.0 + 125.0 * sg / 65536.0;
      rl = -6.0 + 125.0 * (sg >> (16 - bits)) / (2.0 ** bits);
      ix = rx * $exp(17.62 * tc / (243.12 + tc)) / $exp(22.46 * tc / (272.62 + tc));
      ig = rg * $exp(17.62 * tc / (243.12 + tc)) / $exp(22.46 * tc / (272.62 + tc));
      chk("humidity", 16'(int'(rx * 100.0)), 16'(int'(rg * 100.0)));
      chk("legacy humidity", 16'(int'(rx * 100.0)), 16'(int'(rl * 100.0)));
      chk("humidity over ice", 16'(int'(ix * 100.0)), 16'(int'(ig * 100.0)));
    end
  endtask
  // every resolution code, both kinds, timed and read back
  task automatic t_modes;
    int n, m, b;
    logic [3:0] lv;
    logic [15:0] e;
    for (int i = 0; i < 8; i++) begin
      if (i != 0) set_res(i[1:0]);
      adc_sample_in = 16'ha5c3 + i * 16'h1111;
      m  = ms_tab[i] * MS;
      lv = level;
      req(i[2]);
      n = 0;
      while (level === lv && n < 2000) begin
        @(negedge clk_in);
        n++;
      end
      chk("measure time", 16'(m), 16'((n < m || n > m + 3) ? n : m));
      b = bit_tab[i];
      e = (adc_sample_in >> (16 - b)) << (16 - b);
      e[1:0] = {~i[2], 1'b0};
      rd(1'b0, e);
      conv(i[2], b, e, last_w);
    end
  endtask
  // fill to refusal, abort a read, then drain to empty
  task automatic t_full;
    set_res(2'h1);
    for (int k = 1; k < 10; k++) begin
      adc_sample_in = {k[7:0], 8'hff};
      req(1'b0);
      repeat (4 * MS + 6) @(negedge clk_in);
    end
    chk("busy when full", 16'h0001, {15'h0000, busy});
    chk("fifo level", 16'h0008, {12'h000, level});
    rd(1'b1, 16'h0001);
    chk("fifo level", 16'h0008, {12'h000, level});
    for (int k = 1; k < 10; k++) rd(1'b0, {k[7:0], 8'h02});
    chk("fifo level", 16'h0000, {12'h000, level});
    rd(1'b0, 16'hffff);
  endtask
  initial begin
    rst_n_in      = 1'b0;
    meas_req_in   = 1'b0;
    meas_temp_in  = 1'b0;
    res_wr_in     = 1'b0;
    res_code_in   = 2'h0;
    adc_sample_in = 16'h0000;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset;
    t_modes;
    t_full;
    test_done;
  end
endmodule // test_htc_sensor_result
